// ===== hdl/hca_channel_assign.sv
// Notes on behaviour
// - A packet register write queues one byte unless the buffer is full, bit 7 MSB, bit 0 LSB.
// - Receive timeslot enable clear uses the data link, else DS0s.
// - Receive selection mode clear uses the one DS0 the number names.
// - Receive selection mode set uses the receive block set instead.
// - The channel number is assign bits 4 to 0, bit 4 its MSB.
// - Each set receive suppress bit drops one DS0 bit, bit 7 the MSB.
// - Transmit timeslot enable clear feeds the data link, else DS0s.
// - Transmit selection mode clear uses the one DS0 the number names.
// - Transmit selection mode set uses the transmit block set instead.
// - Each set transmit suppress bit drops one DS0 bit, bit 7 the MSB.
// - Empty mid-message queue sets a read-cleared underrun, aborts.
`timescale 1ns/1ps
module hca_channel_assign
  import hca_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic [ADDR_W-1:0] host_addr_i,
  input  wire logic [DATA_W-1:0] host_wdata_i,
  input  wire logic              host_wr_i,
  input  wire logic              host_rd_i,
  output logic [DATA_W-1:0]      host_rdata_o,
  input  wire logic              tx_end_of_message_i,
  input  wire logic              tx_status_read_i,
  output logic [DATA_W-1:0]      tx_byte_o,
  output logic                   tx_byte_valid_o,
  input  wire logic              tx_byte_ready_i,
  output logic                   tx_fifo_full_o,
  output logic                   tx_fifo_empty_o,
  output logic                   tx_underrun_flag_o,
  output logic                   tx_abort_o,
  input  wire logic [CHAN_N-1:0] rx_channel_block_regs_i,
  input  wire logic [CHAN_N-1:0] tx_channel_block_regs_i,
  output logic                   rx_use_fdl_o,
  output logic [CHAN_N-1:0]      rx_channel_sel_o,
  output logic [DATA_W-1:0]      rx_bit_use_o,
  output logic                   tx_use_fdl_o,
  output logic [CHAN_N-1:0]      tx_channel_sel_o,
  output logic [DATA_W-1:0]      tx_bit_use_o
);

  // ----------------------------------------------------------------------
  // channel selection decode
  // ----------------------------------------------------------------------
  function automatic logic [CHAN_N-1:0] hca_chan_sel(
    input logic [DATA_W-1:0] ctrl,
    input logic [CHAN_N-1:0] blk
  );
    logic [CHAN_W-1:0] num;
    logic [CHAN_N-1:0] sel;
    num = ctrl[CHAN_NUM_MSB:CHAN_NUM_LSB];
    sel = NO_CHANNELS;
    if (!ctrl[BIT_TIMESLOT_EN]) begin
      sel = NO_CHANNELS;
    end else if (ctrl[BIT_SEL_MODE]) begin
      sel = blk;
    end else if (num < CHAN_LIMIT) begin
      sel[num] = 1'b1;
    end
    return sel;
  endfunction

  // ----------------------------------------------------------------------
  // host port synchronisers
  // ----------------------------------------------------------------------
  logic [ADDR_W-1:0] addr_s1;
  logic [ADDR_W-1:0] addr_s2;
  logic [DATA_W-1:0] wdata_s1;
  logic [DATA_W-1:0] wdata_s2;
  logic              wr_s1;
  logic              wr_s2;
  logic              wr_d;
  logic              rd_s1;
  logic              rd_s2;
  logic              rd_d;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      addr_s1  <= '0;
      addr_s2  <= '0;
      wdata_s1 <= '0;
      wdata_s2 <= '0;
      wr_s1    <= 1'b0;
      wr_s2    <= 1'b0;
      wr_d     <= 1'b0;
      rd_s1    <= 1'b0;
      rd_s2    <= 1'b0;
      rd_d     <= 1'b0;
    end else begin
      addr_s1  <= host_addr_i;
      addr_s2  <= addr_s1;
      wdata_s1 <= host_wdata_i;
      wdata_s2 <= wdata_s1;
      wr_s1    <= host_wr_i;
      wr_s2    <= wr_s1;
      wr_d     <= wr_s2;
      rd_s1    <= host_rd_i;
      rd_s2    <= rd_s1;
      rd_d     <= rd_s2;
    end
  end

  // ----------------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------------
  wire wr_pulse      = wr_s2 & ~wr_d;
  wire rd_pulse      = rd_s2 & ~rd_d;
  wire wr_fifo       = wr_pulse & (addr_s2 == ADDR_TX_FIFO_DATA);
  wire wr_rx_assign  = wr_pulse & (addr_s2 == ADDR_RX_ASSIGN);
  wire wr_rx_supp    = wr_pulse & (addr_s2 == ADDR_RX_SUPPRESS);
  wire wr_tx_assign  = wr_pulse & (addr_s2 == ADDR_TX_ASSIGN);
  wire wr_tx_supp    = wr_pulse & (addr_s2 == ADDR_TX_SUPPRESS);

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] rx_assign;
  logic [DATA_W-1:0] rx_supp;
  logic [DATA_W-1:0] tx_assign;
  logic [DATA_W-1:0] tx_supp;
  logic [DATA_W-1:0] read_data;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rx_assign <= RST_ASSIGN;
      rx_supp   <= RST_SUPPRESS;
      tx_assign <= RST_ASSIGN;
      tx_supp   <= RST_SUPPRESS;
    end else begin
      if (wr_rx_assign) rx_assign <= wdata_s2;
      if (wr_rx_supp) rx_supp <= wdata_s2;
      if (wr_tx_assign) tx_assign <= wdata_s2;
      if (wr_tx_supp) tx_supp <= wdata_s2;
    end
  end

  // packet data register is write only and reads as zero
  assign read_data = (addr_s2 == ADDR_RX_ASSIGN)   ? rx_assign :
                     (addr_s2 == ADDR_RX_SUPPRESS) ? rx_supp   :
                     (addr_s2 == ADDR_TX_ASSIGN)   ? tx_assign :
                     (addr_s2 == ADDR_TX_SUPPRESS) ? tx_supp   :
                     READ_ZERO;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      host_rdata_o <= READ_ZERO;
    end else if (rd_pulse) begin
      host_rdata_o <= read_data;
    end
  end

  // ----------------------------------------------------------------------
  // channel and bit assignment outputs
  // ----------------------------------------------------------------------
  wire [CHAN_N-1:0] next_rx_sel = hca_chan_sel(rx_assign,
                                               rx_channel_block_regs_i);
  wire [CHAN_N-1:0] next_tx_sel = hca_chan_sel(tx_assign,
                                               tx_channel_block_regs_i);
  wire [DATA_W-1:0] next_rx_use;
  wire [DATA_W-1:0] next_tx_use;

  genvar b;
  generate
    for (b = 0; b < DATA_W; b++) begin : g_bit_use
      assign next_rx_use[b] = ~rx_supp[b];
      assign next_tx_use[b] = ~tx_supp[b];
    end
  endgenerate

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rx_use_fdl_o     <= 1'b1;
      tx_use_fdl_o     <= 1'b1;
      rx_channel_sel_o <= NO_CHANNELS;
      tx_channel_sel_o <= NO_CHANNELS;
      rx_bit_use_o     <= ALL_BITS_USED;
      tx_bit_use_o     <= ALL_BITS_USED;
    end else begin
      rx_use_fdl_o     <= ~rx_assign[BIT_TIMESLOT_EN];
      tx_use_fdl_o     <= ~tx_assign[BIT_TIMESLOT_EN];
      rx_channel_sel_o <= next_rx_sel;
      tx_channel_sel_o <= next_tx_sel;
      rx_bit_use_o     <= next_rx_use;
      tx_bit_use_o     <= next_tx_use;
    end
  end

  // ----------------------------------------------------------------------
  // transmit packet buffer
  // ----------------------------------------------------------------------
  logic fifo_in_ready;

  hca_buf2 u_tx_buf (
    .ref_clk_i   (ref_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (wr_fifo),
    .in_data_i   (wdata_s2),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (tx_byte_valid_o),
    .out_data_o  (tx_byte_o),
    .out_ready_i (tx_byte_ready_i),
    .full_o      (tx_fifo_full_o),
    .empty_o     (tx_fifo_empty_o)
  );

  // ----------------------------------------------------------------------
  // message tracking and underrun
  // ----------------------------------------------------------------------
  hca_tx_state_t tx_state;
  hca_tx_state_t next_tx_state;
  logic          next_underrun;

  wire byte_taken   = tx_byte_valid_o & tx_byte_ready_i;
  wire underrun_evt = (tx_state == HCA_TX_SEND) & ~tx_byte_valid_o &
                      tx_byte_ready_i & ~tx_end_of_message_i;

  always_comb begin
    case (tx_state)
      HCA_TX_IDLE: begin
        next_tx_state = byte_taken ? HCA_TX_SEND : HCA_TX_IDLE;
      end
      HCA_TX_SEND: begin
        if (underrun_evt) begin
          next_tx_state = HCA_TX_ABORT;
        end else if (tx_end_of_message_i & ~tx_byte_valid_o) begin
          next_tx_state = HCA_TX_IDLE;
        end else begin
          next_tx_state = HCA_TX_SEND;
        end
      end
      HCA_TX_ABORT: begin
        next_tx_state = HCA_TX_IDLE;
      end
      default: begin
        next_tx_state = HCA_TX_IDLE;
      end
    endcase
  end

  // a new underrun beats a clearing read in the same cycle
  assign next_underrun = underrun_evt |
                         (tx_underrun_flag_o & ~tx_status_read_i);
  assign tx_abort_o    = (tx_state == HCA_TX_ABORT);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      tx_state           <= HCA_TX_IDLE;
      tx_underrun_flag_o <= 1'b0;
    end else begin
      tx_state           <= next_tx_state;
      tx_underrun_flag_o <= next_underrun;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  wire [CHAN_W-1:0] rx_num = rx_assign[CHAN_NUM_MSB:CHAN_NUM_LSB];
  wire [CHAN_W-1:0] tx_num = tx_assign[CHAN_NUM_MSB:CHAN_NUM_LSB];

  AST_FIFO_BYTE: assert property (
    wr_fifo && tx_fifo_empty_o |=> tx_byte_valid_o &&
      tx_byte_o == $past(wdata_s2))
    else $error("queued byte not presented intact");

  AST_RX_FDL: assert property (
    !rx_assign[BIT_TIMESLOT_EN] |=> rx_use_fdl_o &&
      rx_channel_sel_o == NO_CHANNELS)
    else $error("receive not on data link");

  AST_RX_SINGLE: assert property (
    rx_assign[BIT_TIMESLOT_EN] && !rx_assign[BIT_SEL_MODE] &&
      rx_num < CHAN_LIMIT |=> $onehot(rx_channel_sel_o) &&
      rx_channel_sel_o[$past(rx_num)])
    else $error("receive single channel wrong");

  AST_RX_BLOCK: assert property (
    rx_assign[BIT_TIMESLOT_EN] && rx_assign[BIT_SEL_MODE] |=>
      rx_channel_sel_o == $past(rx_channel_block_regs_i))
    else $error("receive block set not used");

  AST_RX_SUPP: assert property (
    ##1 rx_bit_use_o == ~$past(rx_supp))
    else $error("receive bit suppress wrong");

  AST_TX_FDL: assert property (
    !tx_assign[BIT_TIMESLOT_EN] |=> tx_use_fdl_o &&
      tx_channel_sel_o == NO_CHANNELS)
    else $error("transmit not on data link");

  AST_TX_SINGLE: assert property (
    tx_assign[BIT_TIMESLOT_EN] && !tx_assign[BIT_SEL_MODE] &&
      tx_num < CHAN_LIMIT |=> $onehot(tx_channel_sel_o) &&
      tx_channel_sel_o[$past(tx_num)])
    else $error("transmit single channel wrong");

  AST_TX_BLOCK: assert property (
    tx_assign[BIT_TIMESLOT_EN] && tx_assign[BIT_SEL_MODE] |=>
      tx_channel_sel_o == $past(tx_channel_block_regs_i))
    else $error("transmit block set not used");

  AST_TX_SUPP: assert property (
    ##1 tx_bit_use_o == ~$past(tx_supp))
    else $error("transmit bit suppress wrong");

  AST_UNDERRUN_ABORT: assert property (
    underrun_evt |=> tx_abort_o && tx_underrun_flag_o ##1 !tx_abort_o)
    else $error("underrun did not abort");

  AST_UNDERRUN_HOLD: assert property (
    tx_underrun_flag_o && !tx_status_read_i |=> tx_underrun_flag_o)
    else $error("underrun flag lost before read");

  AST_BAD_CHANNEL: assert property (
    tx_assign[BIT_TIMESLOT_EN] && !tx_assign[BIT_SEL_MODE] &&
      tx_num >= CHAN_LIMIT |=> tx_channel_sel_o == NO_CHANNELS)
    else $error("invalid channel selected a timeslot");

  AST_RX_BAD_CHANNEL: assert property (
    rx_assign[BIT_TIMESLOT_EN] && !rx_assign[BIT_SEL_MODE] &&
      rx_num >= CHAN_LIMIT |=> rx_channel_sel_o == NO_CHANNELS)
    else $error("invalid receive channel selected a timeslot");

  COV_FIFO_WRITE: cover property (wr_fifo && fifo_in_ready);
  COV_FIFO_FULL: cover property (tx_fifo_full_o && wr_fifo);
  COV_UNDERRUN: cover property (underrun_evt);
  COV_RX_BLOCK: cover property (rx_assign[BIT_SEL_MODE] &&
                                rx_assign[BIT_TIMESLOT_EN]);

endmodule // hca_channel_assign

// ===== hdl/hca_pkg.sv
package hca_pkg;

  // ----------------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------------
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned CHAN_N    = 24;
  localparam int unsigned CHAN_W    = 5;
  localparam int unsigned BUF_DEPTH = 2;
  localparam int unsigned BUF_CNT_W = 2;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_TX_FIFO_DATA  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_RX_ASSIGN     = 8'h90;
  localparam logic [ADDR_W-1:0] ADDR_RX_SUPPRESS   = 8'h91;
  localparam logic [ADDR_W-1:0] ADDR_TX_ASSIGN     = 8'h92;
  localparam logic [ADDR_W-1:0] ADDR_TX_SUPPRESS   = 8'h93;

  // ----------------------------------------------------------------------
  // field positions of the channel assign registers
  // ----------------------------------------------------------------------
  localparam int unsigned BIT_TIMESLOT_EN = 7;
  localparam int unsigned BIT_UNASSIGNED  = 6;
  localparam int unsigned BIT_SEL_MODE    = 5;
  localparam int unsigned CHAN_NUM_MSB    = 4;
  localparam int unsigned CHAN_NUM_LSB    = 0;

  // ----------------------------------------------------------------------
  // reset and constant values
  // ----------------------------------------------------------------------
  localparam logic [DATA_W-1:0]    RST_ASSIGN    = 8'h00;
  localparam logic [DATA_W-1:0]    RST_SUPPRESS  = 8'h00;
  localparam logic [DATA_W-1:0]    READ_ZERO     = 8'h00;
  localparam logic [DATA_W-1:0]    ALL_BITS_USED = 8'hFF;
  localparam logic [CHAN_W-1:0]    CHAN_LIMIT    = 5'h18;
  localparam logic [CHAN_N-1:0]    NO_CHANNELS   = 24'h000000;
  localparam logic [BUF_CNT_W-1:0] BUF_FULL_CNT  = 2'h2;
  localparam logic [BUF_CNT_W-1:0] BUF_EMPTY_CNT = 2'h0;

  // ----------------------------------------------------------------------
  // transmit message tracking
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    HCA_TX_IDLE  = 2'b00,
    HCA_TX_SEND  = 2'b01,
    HCA_TX_ABORT = 2'b11
  } hca_tx_state_t;

endpackage

// ===== hdl/hca_buf2.sv
`timescale 1ns/1ps
module hca_buf2
  import hca_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              in_valid_i,
  input  wire logic [DATA_W-1:0] in_data_i,
  output logic                   in_ready_o,
  output logic                   out_valid_o,
  output logic [DATA_W-1:0]      out_data_o,
  input  wire logic              out_ready_i,
  output logic                   full_o,
  output logic                   empty_o
);

  logic [DATA_W-1:0]    mem [BUF_DEPTH];
  logic                 wr_idx;
  logic                 rd_idx;
  logic [BUF_CNT_W-1:0] count;
  logic [BUF_CNT_W-1:0] next_count;
  wire                  push;
  wire                  pop;

  // ----------------------------------------------------------------------
  // handshake decode
  // ----------------------------------------------------------------------
  assign full_o      = (count == BUF_FULL_CNT);
  assign empty_o     = (count == BUF_EMPTY_CNT);
  assign in_ready_o  = ~full_o;
  assign out_valid_o = ~empty_o;
  assign out_data_o  = mem[rd_idx];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign next_count  = count + BUF_CNT_W'(push) - BUF_CNT_W'(pop);

  // ----------------------------------------------------------------------
  // pointers and storage
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wr_idx <= 1'b0;
      rd_idx <= 1'b0;
      count  <= BUF_EMPTY_CNT;
    end else begin
      if (push) wr_idx <= ~wr_idx;
      if (pop) rd_idx <= ~rd_idx;
      count <= next_count;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (push) mem[wr_idx] <= in_data_i;
  end

endmodule // hca_buf2

// ===== sim/hca_host_model.sv
`timescale 1ns/1ps
module hca_host_model
  import hca_pkg::*;
(
  input  wire logic              ref_clk_i,
  output logic [ADDR_W-1:0]      host_addr_o,
  output logic [DATA_W-1:0]      host_wdata_o,
  output logic                   host_wr_o,
  output logic                   host_rd_o,
  input  wire logic [DATA_W-1:0] host_rdata_i
);
  initial begin
    host_addr_o  = 8'h00;
    host_wdata_o = 8'h00;
    host_wr_o    = 1'b0;
    host_rd_o    = 1'b0;
  end

  // ----------------------------------------------------------------------
  // strobe cycles: change just after an edge, hold through the sync stages
  // ----------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #10;
  endtask

  task automatic write_reg(input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] v;
    v = d;
    if (a == ADDR_RX_ASSIGN || a == ADDR_TX_ASSIGN) begin
      v[BIT_UNASSIGNED] = 1'b0;
    end
    tick(1);
    host_addr_o  = a;
    host_wdata_o = v;
    tick(2);
    host_wr_o = 1'b1;
    tick(3);
    host_wr_o = 1'b0;
    tick(2);
    // released bus no longer shows the last value
    host_addr_o  = ~a;
    host_wdata_o = ~v;
    tick(1);
  endtask

  task automatic read_reg(input  logic [ADDR_W-1:0] a,
                          output logic [DATA_W-1:0] d);
    tick(1);
    host_addr_o = a;
    tick(2);
    host_rd_o = 1'b1;
    tick(3);
    host_rd_o = 1'b0;
    tick(1);
    d = host_rdata_i;
    tick(1);
    host_addr_o = ~a;
    tick(1);
  endtask
endmodule // hca_host_model

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb;
  import hca_pkg::*;
  logic              ref_clk_i, sys_rst_i, eom, st_rd, rdy, hwr, hrd;
  logic [ADDR_W-1:0] haddr;
  logic [DATA_W-1:0] hwd, hrdata, tbyte, rbu, tbu, d;
  logic              tvalid, tfull, tempty, uflag, abrt, rfdl, tfdl;
  logic [CHAN_N-1:0] rblk, tblk, rsel, tsel;
  int                fail_count, samples_checked, abort_count;
  logic [5:0]        chans [5] = '{6'd0, 6'd5, 6'd23, 6'd24, 6'd31};
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h06;

  // a host read of the status address clears the underrun flag
  assign st_rd = hrd & (haddr == STATUS_ADDR);
  // the transmit block set is the receive set turned by twelve
  assign tblk = {rblk[11:0], rblk[23:12]};

  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  hca_host_model host (.ref_clk_i(ref_clk_i), .host_addr_o(haddr),
    .host_wdata_o(hwd), .host_wr_o(hwr), .host_rd_o(hrd),
    .host_rdata_i(hrdata));

  hca_channel_assign uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .host_addr_i(haddr), .host_wdata_i(hwd), .host_wr_i(hwr),
    .host_rd_i(hrd), .host_rdata_o(hrdata), .tx_end_of_message_i(eom),
    .tx_status_read_i(st_rd), .tx_byte_o(tbyte), .tx_byte_valid_o(tvalid),
    .tx_byte_ready_i(rdy), .tx_fifo_full_o(tfull),
    .tx_fifo_empty_o(tempty), .tx_underrun_flag_o(uflag),
    .tx_abort_o(abrt), .rx_channel_block_regs_i(rblk),
    .tx_channel_block_regs_i(tblk), .rx_use_fdl_o(rfdl),
    .rx_channel_sel_o(rsel), .rx_bit_use_o(rbu), .tx_use_fdl_o(tfdl),
    .tx_channel_sel_o(tsel), .tx_bit_use_o(tbu));

  always @(posedge ref_clk_i) begin
    if (abrt === 1'b1) abort_count++;
  end

  // ----------------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------------
  task automatic chk(input logic [CHAN_N-1:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] e);
    host.read_reg(a, d);
    chk(d, e, "read back");
  endtask

  function automatic logic [CHAN_N-1:0] one_chan(input logic [5:0] c);
    return (c < 6'd24) ? (24'h000001 << c) : 24'h000000;
  endfunction

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fail_count++;
    $display("BAD %0t run did not finish", $time);
    print_verdict();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    fail_count = 0;
    samples_checked = 0;
    abort_count = 0;
    sys_rst_i = 1'b1;
    eom = 1'b1;
    rdy = 1'b0;
    rblk = NO_CHANNELS;
    host.tick(10);
    sys_rst_i = 1'b0;
    host.tick(1);
    chk(rfdl, 1'b1, "rx fdl at reset");
    chk(tfdl, 1'b1, "tx fdl at reset");
    chk(rsel | tsel, 24'h000000, "no channel at reset");
    chk({rbu, tbu}, 16'hFFFF, "all bits used at reset");
    chk({tempty, tfull, tvalid, uflag}, 4'h8, "buffer idle");
    rd_chk(ADDR_RX_ASSIGN, 8'h00);
    rd_chk(ADDR_TX_SUPPRESS, 8'h00);
    // single channel by number, both ends of the range
    for (int i = 0; i < 5; i++) begin
      host.write_reg(ADDR_RX_ASSIGN, 8'h80 | {3'h0, chans[i][4:0]});
      host.write_reg(ADDR_TX_ASSIGN, 8'h80 | {3'h0, chans[i][4:0]});
      chk(rfdl, 1'b0, "rx on ds0");
      chk(rsel, one_chan(chans[i]), "rx one");
      chk(tfdl, 1'b0, "tx on ds0");
      chk(tsel, one_chan(chans[i]), "tx one");
    end
    rd_chk(ADDR_TX_ASSIGN, 8'h9F);
    // block mode ignores the channel number
    rblk = 24'hA5A5A5;
    host.write_reg(ADDR_RX_ASSIGN, 8'hA3);
    host.write_reg(ADDR_TX_ASSIGN, 8'hA3);
    chk(rsel, 24'hA5A5A5, "rx block");
    chk(tsel, 24'h5A5A5A, "tx block");
    rblk = one_chan(6'd23) | one_chan(6'd0);
    host.tick(2);
    chk(rsel, 24'h800001, "rx block follows");
    chk(tsel, 24'h001800, "tx block follows");
    // bit suppression
    host.write_reg(ADDR_RX_SUPPRESS, 8'h81);
    host.write_reg(ADDR_TX_SUPPRESS, 8'h40);
    chk(rbu, 8'h7E, "rx suppress");
    chk(tbu, 8'hBF, "tx suppress");
    rd_chk(ADDR_RX_SUPPRESS, 8'h81);
    rd_chk(ADDR_TX_SUPPRESS, 8'h40);
    // back to the data link
    host.write_reg(ADDR_RX_ASSIGN, 8'h03);
    host.write_reg(ADDR_TX_ASSIGN, 8'h23);
    chk(rfdl, 1'b1, "rx back to fdl");
    chk(tfdl, 1'b1, "tx back to fdl");
    chk(rsel | tsel, 24'h000000, "no ds0 on fdl");
    rd_chk(ADDR_TX_FIFO_DATA, 8'h00);
    rd_chk(8'h55, 8'h00);
    // fill the buffer while the engine stalls, then drain it
    host.write_reg(ADDR_TX_FIFO_DATA, 8'hA1);
    host.write_reg(ADDR_TX_FIFO_DATA, 8'h5C);
    chk({tfull, tempty}, 2'b10, "buffer full");
    host.write_reg(ADDR_TX_FIFO_DATA, 8'h33);
    chk(tbyte, 8'hA1, "first byte");
    rdy = 1'b1;
    host.tick(1);
    rdy = 1'b0;
    chk({tvalid, tbyte}, 9'h15C, "second byte");
    rdy = 1'b1;
    host.tick(1);
    chk({tvalid, tempty}, 2'b01, "third byte dropped");
    host.tick(2);
    rdy = 1'b0;
    chk(uflag, 1'b0, "quiet end of message");
    chk(24'(abort_count), 24'h000000, "no abort on quiet end");
    // underrun: engine keeps asking with no end of message
    eom = 1'b0;
    rdy = 1'b1;
    host.write_reg(ADDR_TX_FIFO_DATA, 8'h7E);
    host.tick(3);
    rdy = 1'b0;
    chk(uflag, 1'b1, "underrun flag");
    chk(24'(abort_count), 24'h000001, "one abort pulse");
    rd_chk(STATUS_ADDR, 8'h00);
    chk(uflag, 1'b0, "flag cleared on read");
    print_verdict();
  end
endmodule // tb
